// *** core/acp_pkg.sv ***
/*
 * Shared constants, carriers and decode functions for the audio port clock
 * configuration and monitor block.
 * Assumes a single 40 MHz system clock and an 8-bit register port.
 */
package acp_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    // No frame edge within this time means the port is dead
    localparam int MON_TIMEOUT_US = 300;
    localparam int MON_TIMEOUT_CYC = MON_TIMEOUT_US * (CLK_HZ / 1_000_000);
    // Tolerance window on measured frame period, in percent
    localparam int RATE_TOL_LO_PCT = 98;
    localparam int RATE_TOL_HI_PCT = 102;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_MST_CFG0 = 8'h13;
    localparam logic [7:0] ADDR_MASTER_RATE_RATIO_CONFIG = 8'h14;
    localparam logic [7:0] ADDR_MON_STS = 8'h15;
    localparam logic [7:0] ADDR_CLOCK_SOURCE_CONFIG = 8'h16;
    localparam logic [7:0] ADDR_PDM_CFG = 8'h1F;
    localparam logic [7:0] ADDR_IRQ_STS = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h31;

    localparam logic [7:0] RST_MST_CFG0 = 8'h02;
    localparam logic [7:0] RST_MASTER_RATE_RATIO_CONFIG = 8'h48;
    localparam logic [7:0] RST_MON_STS = 8'hFF;
    localparam logic [7:0] RST_CLOCK_SOURCE_CONFIG = 8'h10;
    localparam logic [7:0] RST_PDM_CFG = 8'h40;
    localparam logic [1:0] RST_IRQ = 2'h0;
    localparam logic [7:0] CLOCK_SOURCE_CONFIG_WMASK = 8'hF8;

    // Field positions
    localparam int POS_ROLE = 7;
    localparam int POS_AUTO_OFF = 6;
    localparam int POS_PLL_BYP = 5;
    localparam int POS_GATE = 4;
    localparam int POS_FAM44 = 3;
    localparam int POS_FIXED_FREQ = 0;
    localparam int POS_RATE = 4;
    localparam int POS_RATIO = 0;
    localparam int POS_ROOT_SRC = 7;
    localparam int POS_SPEC_MODE = 6;
    localparam int POS_MCLK_RATIO = 3;
    localparam int IRQ_CHANGE = 0;
    localparam int IRQ_INVALID = 1;

    localparam logic [3:0] CODE_INVALID = 4'hF;
    localparam logic [3:0] RATE_CODE_MAX = 4'h8;
    localparam logic [3:0] RATIO_CODE_MAX = 4'hC;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic run;
        logic gate;
        logic fam44;
        logic [3:0] rate;
        logic [3:0] ratio;
    } acp_gen_cfg_s;

    // ----------------------------------------------------------------
    // Decode tables
    // ----------------------------------------------------------------
    function automatic int acp_fs_hz(input logic [3:0] code, input logic fam44);
        int base;
        base = fam44 ? 7350 : 8000;
        unique case (code)
            4'h0: acp_fs_hz = base;
            4'h1: acp_fs_hz = base * 2;
            4'h2: acp_fs_hz = base * 3;
            4'h3: acp_fs_hz = base * 4;
            4'h4: acp_fs_hz = base * 6;
            4'h5: acp_fs_hz = base * 12;
            4'h6: acp_fs_hz = base * 24;
            4'h7: acp_fs_hz = base * 48;
            4'h8: acp_fs_hz = base * 96;
            default: acp_fs_hz = 0;
        endcase
    endfunction

    function automatic int acp_bclk_ratio(input logic [3:0] code);
        unique case (code)
            4'h0: acp_bclk_ratio = 16;
            4'h1: acp_bclk_ratio = 24;
            4'h2: acp_bclk_ratio = 32;
            4'h3: acp_bclk_ratio = 48;
            4'h4: acp_bclk_ratio = 64;
            4'h5: acp_bclk_ratio = 96;
            4'h6: acp_bclk_ratio = 128;
            4'h7: acp_bclk_ratio = 192;
            4'h8: acp_bclk_ratio = 256;
            4'h9: acp_bclk_ratio = 384;
            4'hA: acp_bclk_ratio = 512;
            4'hB: acp_bclk_ratio = 1024;
            4'hC: acp_bclk_ratio = 2048;
            default: acp_bclk_ratio = 0;
        endcase
    endfunction

    function automatic logic [11:0] acp_mclk_ratio(input logic [2:0] code);
        unique case (code)
            3'h0: acp_mclk_ratio = 12'h040;
            3'h1: acp_mclk_ratio = 12'h100;
            3'h2: acp_mclk_ratio = 12'h180;
            3'h3: acp_mclk_ratio = 12'h200;
            3'h4: acp_mclk_ratio = 12'h300;
            3'h5: acp_mclk_ratio = 12'h400;
            3'h6: acp_mclk_ratio = 12'h600;
            default: acp_mclk_ratio = 12'h900;
        endcase
    endfunction

endpackage

// *** core/acp_clk_gen.sv ***
/*
 * Master-mode bit clock and frame sync generator.
 * Assumes the configuration carrier is stable for many cycles at a time;
 * a change restarts the frame.
 */
`timescale 1ns/1ps
`default_nettype none
module acp_clk_gen import acp_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire acp_gen_cfg_s i_cfg,
    output logic o_bclk,
    output logic o_frame_sync
);

    // ----------------------------------------------------------------
    // Fractional divider: toggles the bit clock at twice fs*ratio
    // ----------------------------------------------------------------
    localparam logic [33:0] CLK_HZ_W = 34'(CLK_HZ);
    logic [33:0] step;
    logic [33:0] acc_ff, nxt_acc;
    logic bclk_ff, nxt_bclk;
    logic frame_sync_ff, nxt_frame_sync;
    logic [11:0] bit_ff, nxt_bit;
    acp_gen_cfg_s cfg_ff;
    logic [11:0] last_bit;

    assign step = 34'(acp_fs_hz(i_cfg.rate, i_cfg.fam44)) * 34'(acp_bclk_ratio(i_cfg.ratio)) * 34'h2;
    assign last_bit = 12'(acp_bclk_ratio(i_cfg.ratio) - 1);

    // Next toggle; rates above half the clock saturate at one toggle a cycle
    always_comb begin
        nxt_acc = acc_ff;
        nxt_bclk = bclk_ff;
        nxt_frame_sync = frame_sync_ff;
        nxt_bit = bit_ff;
        if (!i_cfg.run || i_cfg.gate || (i_cfg != cfg_ff)) begin
            nxt_acc = 34'h0;
            nxt_bclk = 1'b0;
            nxt_frame_sync = 1'b0;
            nxt_bit = 12'h000;
        end else if (acc_ff + step >= CLK_HZ_W) begin
            nxt_acc = (step >= CLK_HZ_W) ? acc_ff : acc_ff + step - CLK_HZ_W;
            nxt_bclk = ~bclk_ff;
            if (bclk_ff) begin
                // Falling edge: advance bit, frame sync high for bit 0
                nxt_bit = (bit_ff == last_bit) ? 12'h000 : bit_ff + 12'h001;
                nxt_frame_sync = (bit_ff == last_bit);
            end
        end else begin
            nxt_acc = acc_ff + step;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            acc_ff <= 34'h0;
            bclk_ff <= 1'b0;
            frame_sync_ff <= 1'b0;
            bit_ff <= 12'h000;
            cfg_ff <= '0;
        end else begin
            acc_ff <= nxt_acc;
            bclk_ff <= nxt_bclk;
            frame_sync_ff <= nxt_frame_sync;
            bit_ff <= nxt_bit;
            cfg_ff <= i_cfg;
        end
    end

    assign o_bclk = bclk_ff;
    assign o_frame_sync = frame_sync_ff;

    chk_gen_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !i_cfg.run |=> !bclk_ff && !frame_sync_ff)
        else $error("generator active while not running");

endmodule
`default_nettype wire

// *** core/acp_top.sv ***
/*
 * Audio port clock configuration and monitor: registers, root clock
 * selection, master-mode clock generation and frame rate / ratio detection.
 * Assumes pins arrive asynchronously and a 40 MHz system clock.
 */
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module acp_top import acp_pkg::*; #(
    parameter int TIMEOUT_CYC = MON_TIMEOUT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_bclk,
    input wire logic i_frame_sync,
    output logic o_bclk,
    output logic o_bclk_oe_b,
    output logic o_frame_sync,
    output logic o_frame_sync_oe_b,
    output logic o_pll_en,
    output logic o_root_sel_mclk,
    output logic o_mclk_by_ratio,
    output logic [2:0] o_fixed_root_freq_select,
    output logic [11:0] o_mclk_ratio,
    output logic o_irq
);

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [7:0] cfg0_ff, nxt_cfg0;
    logic [7:0] cfg1_ff, nxt_cfg1;
    logic [7:0] src_ff, nxt_src;
    logic [7:0] pdm_ff, nxt_pdm;
    logic [1:0] irq_mask_ff, nxt_irq_mask;
    logic [1:0] irq_sts_ff, nxt_irq_sts;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [7:0] sts_ff, nxt_sts;
    logic [1:0] irq_ev;

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = i_wr && (i_addr == a);
    endfunction

    // Software writes; status register is read-only
    always_comb begin
        nxt_cfg0 = wr_hit(ADDR_MST_CFG0) ? i_wdata : cfg0_ff;
        nxt_cfg1 = wr_hit(ADDR_MASTER_RATE_RATIO_CONFIG) ? i_wdata : cfg1_ff;
        nxt_src = wr_hit(ADDR_CLOCK_SOURCE_CONFIG) ? (i_wdata & CLOCK_SOURCE_CONFIG_WMASK) : src_ff;
        nxt_pdm = wr_hit(ADDR_PDM_CFG) ? i_wdata : pdm_ff;
        nxt_irq_mask = wr_hit(ADDR_IRQ_MASK) ? i_wdata[1:0] : irq_mask_ff;
        // Write one clears, but a new event in the same cycle wins
        nxt_irq_sts = (irq_sts_ff & ~(wr_hit(ADDR_IRQ_STS) ? i_wdata[1:0] : 2'h0)) | irq_ev;
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_MST_CFG0: nxt_rdata = cfg0_ff;
                ADDR_MASTER_RATE_RATIO_CONFIG: nxt_rdata = cfg1_ff;
                ADDR_MON_STS: nxt_rdata = sts_ff;
                ADDR_CLOCK_SOURCE_CONFIG: nxt_rdata = src_ff;
                ADDR_PDM_CFG: nxt_rdata = pdm_ff;
                ADDR_IRQ_STS: nxt_rdata = {6'h00, irq_sts_ff};
                ADDR_IRQ_MASK: nxt_rdata = {6'h00, irq_mask_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cfg0_ff <= RST_MST_CFG0;
            cfg1_ff <= RST_MASTER_RATE_RATIO_CONFIG;
            src_ff <= RST_CLOCK_SOURCE_CONFIG;
            pdm_ff <= RST_PDM_CFG;
            irq_mask_ff <= RST_IRQ;
            irq_sts_ff <= RST_IRQ;
            rdata_ff <= 8'h00;
        end else begin
            cfg0_ff <= nxt_cfg0;
            cfg1_ff <= nxt_cfg1;
            src_ff <= nxt_src;
            pdm_ff <= nxt_pdm;
            irq_mask_ff <= nxt_irq_mask;
            irq_sts_ff <= nxt_irq_sts;
            rdata_ff <= nxt_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Clock tree decisions
    // ----------------------------------------------------------------
    logic is_master, is_auto, slave_auto, pll_byp, root_mclk, ratio_used;
    logic [3:0] prog_rate, prog_ratio;
    acp_gen_cfg_s gen_cfg;
    logic ctl_pll_ff, ctl_root_ff, ctl_mode_ff, ctl_oe_b_ff, irq_ff;
    logic [2:0] ctl_freq_ff;
    logic [11:0] ctl_ratio_ff;

    assign is_master = cfg0_ff[POS_ROLE];
    assign is_auto = !cfg0_ff[POS_AUTO_OFF];
    assign slave_auto = !is_master && is_auto;
    assign pll_byp = is_auto && cfg0_ff[POS_PLL_BYP];
    assign root_mclk = slave_auto && pll_byp && src_ff[POS_ROOT_SRC];
    assign ratio_used = is_master || root_mclk;
    assign prog_rate = cfg1_ff[POS_RATE+:4];
    assign prog_ratio = cfg1_ff[POS_RATIO+:4];

    // Reserved programmed codes keep the generator quiet
    always_comb begin
        gen_cfg.run = is_master && (prog_rate <= RATE_CODE_MAX) && (prog_ratio <= RATIO_CODE_MAX);
        gen_cfg.gate = cfg0_ff[POS_GATE];
        gen_cfg.fam44 = cfg0_ff[POS_FAM44];
        gen_cfg.rate = prog_rate;
        gen_cfg.ratio = prog_ratio;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ctl_pll_ff <= 1'b1;
            ctl_root_ff <= 1'b0;
            ctl_mode_ff <= 1'b0;
            ctl_freq_ff <= 3'h0;
            ctl_ratio_ff <= 12'h000;
            ctl_oe_b_ff <= 1'b1;
            irq_ff <= 1'b0;
        end else begin
            ctl_pll_ff <= !pll_byp;
            ctl_root_ff <= root_mclk;
            ctl_mode_ff <= is_auto && src_ff[POS_SPEC_MODE];
            ctl_freq_ff <= (is_auto && !src_ff[POS_SPEC_MODE]) ? cfg0_ff[POS_FIXED_FREQ+:3] : 3'h0;
            ctl_ratio_ff <= ratio_used ? acp_mclk_ratio(src_ff[POS_MCLK_RATIO+:3]) : 12'h000;
            ctl_oe_b_ff <= !is_master;
            irq_ff <= |(nxt_irq_sts & nxt_irq_mask);
        end
    end

    acp_clk_gen u_gen (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_cfg(gen_cfg),
        .o_bclk(o_bclk),
        .o_frame_sync(o_frame_sync)
    );

    // ----------------------------------------------------------------
    // Pin synchronisers and edge finding
    // ----------------------------------------------------------------
    logic [1:0] pin_in;
    logic [1:0] sync1_ff, sync2_ff, prev_ff;
    logic [1:0] mon_cur;
    logic bclk_rise, frame_sync_rise;

    assign pin_in = {i_frame_sync, i_bclk};
    generate
        for (genvar g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge i_clk) begin
                if (!i_rst_b) begin
                    sync1_ff[g] <= 1'b0;
                    sync2_ff[g] <= 1'b0;
                    prev_ff[g] <= 1'b0;
                end else begin
                    sync1_ff[g] <= pin_in[g];
                    sync2_ff[g] <= sync1_ff[g];
                    prev_ff[g] <= mon_cur[g];
                end
            end
        end
    endgenerate

    // As master the monitor watches its own generated clocks
    assign mon_cur = is_master ? {o_frame_sync, o_bclk} : sync2_ff;
    assign bclk_rise = mon_cur[0] && !prev_ff[0];
    assign frame_sync_rise = mon_cur[1] && !prev_ff[1];

    // ----------------------------------------------------------------
    // Frame monitor
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MON_IDLE = 2'b01,
        MON_MEAS = 2'b10
    } acp_mon_e;

    acp_mon_e mon_ff, nxt_mon;
    logic [15:0] cyc_ff, nxt_cyc;
    logic [11:0] bits_ff, nxt_bits;

    function automatic logic [3:0] rate_code(input logic [15:0] period);
        logic [3:0] code;
        code = CODE_INVALID;
        for (int k = 0; k <= 8; k++) begin
            if (period >= 16'((CLK_HZ / 100 * RATE_TOL_LO_PCT) / acp_fs_hz(4'(k), 1'b0)) &&
                period <= 16'((CLK_HZ / 100 * RATE_TOL_HI_PCT) / acp_fs_hz(4'(k), 1'b1))) begin
                code = 4'(k);
            end
        end
        rate_code = code;
    endfunction

    function automatic logic [3:0] ratio_code(input logic [11:0] n);
        logic [3:0] code;
        code = CODE_INVALID;
        for (int k = 0; k <= 12; k++) begin
            if (n == 12'(acp_bclk_ratio(4'(k)))) begin
                code = 4'(k);
            end
        end
        ratio_code = code;
    endfunction

    // Measure one frame from sync edge to sync edge; timeout marks invalid
    always_comb begin
        nxt_mon = mon_ff;
        nxt_sts = sts_ff;
        nxt_cyc = (cyc_ff == 16'hFFFF) ? cyc_ff : cyc_ff + 16'h0001;
        nxt_bits = (bclk_rise && bits_ff != 12'hFFF) ? bits_ff + 12'h001 : bits_ff;
        irq_ev = 2'h0;
        if (frame_sync_rise) begin
            nxt_mon = MON_MEAS;
            nxt_cyc = 16'h0000;
            nxt_bits = {11'h000, bclk_rise};
            if (mon_ff == MON_MEAS) begin
                nxt_sts = {rate_code(cyc_ff + 16'h0001), ratio_code(bits_ff)};
            end
        end else if (32'(cyc_ff) >= TIMEOUT_CYC - 1) begin
            nxt_mon = MON_IDLE;
            nxt_sts = RST_MON_STS;
            nxt_cyc = 16'h0000;
        end
        irq_ev[IRQ_CHANGE] = (nxt_sts != sts_ff);
        irq_ev[IRQ_INVALID] = irq_ev[IRQ_CHANGE] &&
            (nxt_sts[7:4] == CODE_INVALID || nxt_sts[3:0] == CODE_INVALID);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            mon_ff <= MON_IDLE;
            sts_ff <= RST_MON_STS;
            cyc_ff <= 16'h0000;
            bits_ff <= 12'h000;
        end else begin
            mon_ff <= nxt_mon;
            sts_ff <= nxt_sts;
            cyc_ff <= nxt_cyc;
            bits_ff <= nxt_bits;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_rdata = rdata_ff;
    assign o_bclk_oe_b = ctl_oe_b_ff;
    assign o_frame_sync_oe_b = ctl_oe_b_ff;
    assign o_pll_en = ctl_pll_ff;
    assign o_root_sel_mclk = ctl_root_ff;
    assign o_mclk_by_ratio = ctl_mode_ff;
    assign o_fixed_root_freq_select = ctl_freq_ff;
    assign o_mclk_ratio = ctl_ratio_ff;
    assign o_irq = irq_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_sts_after_reset: assert property (@(posedge i_clk) $rose(i_rst_b) |-> sts_ff == 8'hFF)
        else $error("monitor status not all ones after reset");
    chk_rate_code_legal: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        sts_ff[7:4] <= 4'h8 || sts_ff[7:4] == 4'hF)
        else $error("reserved detected rate code");
    chk_ratio_code_legal: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        sts_ff[3:0] <= 4'hC || sts_ff[3:0] == 4'hF)
        else $error("reserved detected ratio code");
    chk_slave_ignores_prog: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        slave_auto |-> !gen_cfg.run)
        else $error("generator runs as slave");
    chk_root_select: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!cfg0_ff[7] && !cfg0_ff[6] && cfg0_ff[5] && src_ff[7]) |=> o_root_sel_mclk)
        else $error("master clock root not selected");
    chk_pll_bypass: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $past(cfg0_ff[6]) |-> o_pll_en)
        else $error("pll bypassed outside automatic mode");
    chk_status_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_rd && i_addr == 8'h15) |=> o_rdata == $past(sts_ff))
        else $error("status read data wrong");
    chk_master_drive: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        cfg0_ff[7] ##1 cfg0_ff[7] |-> !o_bclk_oe_b && !o_frame_sync_oe_b)
        else $error("master not driving clocks");
    chk_mclk_ratio_max: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (cfg0_ff[7] && src_ff[5:3] == 3'h7) |=> o_mclk_ratio == 12'h900)
        else $error("master clock ratio wrong");
    chk_spec_mode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_mclk_by_ratio |-> o_fixed_root_freq_select == 3'h0)
        else $error("fixed frequency shown in ratio mode");
    chk_prog_reset: assert property (@(posedge i_clk) $rose(i_rst_b) |-> cfg1_ff == 8'h48)
        else $error("programmed rate or ratio reset wrong");

endmodule
`default_nettype wire

// *** verif/acp_host_model.sv ***
/*
 * Host-side serial port clock source used while the block is a slave.
 * Assumes the bench releases the host pins whenever the device drives them.
 */
`timescale 1ns/1ps
`default_nettype none
module acp_host_model (
    input wire logic i_run,
    input wire logic [11:0] i_bits,
    input wire logic [15:0] i_frame_ns,
    output logic o_bclk,
    output logic o_frame_sync
);
    // Frames of i_bits clocks at 200 ns; clock stands still between frames
    initial begin
        o_bclk = 1'b0;
        o_frame_sync = 1'b0;
        forever begin
            wait (i_run);
            for (int b = 0; b < i_bits; b++) begin
                o_frame_sync = (b == 0);
                #100 o_bclk = 1'b1;
                #100 o_bclk = 1'b0;
            end
            o_frame_sync = 1'b0;
            #(i_frame_ns - i_bits * 200);
        end
    end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
/*
 * Self-checking bench for acp_top: register port tasks and scenarios.
 * Assumes the host model drives the pins while the device is a slave.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench import acp_pkg::*;;
    logic i_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, run = 0;
    logic [7:0] i_addr = 0, i_wdata = 0, rdata;
    logic bclk, bclk_oe_b, frame_sync, frame_sync_oe_b, pll_en, root, by_ratio, irq, h_bclk, h_frame_sync, pb;
    logic [2:0] ffs;
    logic [11:0] mratio, hbits = 12'd64;
    logic [15:0] hframe = 16'd20833;
    logic [11:0] tbl [8] = '{12'h040, 12'h100, 12'h180, 12'h200, 12'h300, 12'h400, 12'h600, 12'h900};
    int errors = 0, comparisons = 0, cyc = 0, n, st;
    // Shared pins: the device owns the wire while its enable is low, the host otherwise
    wire pin_bclk = bclk_oe_b ? h_bclk : bclk;
    wire pin_frame_sync = frame_sync_oe_b ? h_frame_sync : frame_sync;
    acp_host_model u_host (.i_run(run), .i_bits(hbits), .i_frame_ns(hframe), .o_bclk(h_bclk), .o_frame_sync(h_frame_sync));
    // Short monitor timeout keeps the dead-port case quick
    acp_top #(.TIMEOUT_CYC(1200)) u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_bclk(pin_bclk), .i_frame_sync(pin_frame_sync), .o_bclk(bclk),
        .o_bclk_oe_b(bclk_oe_b), .o_frame_sync(frame_sync), .o_frame_sync_oe_b(frame_sync_oe_b), .o_pll_en(pll_en),
        .o_root_sel_mclk(root), .o_mclk_by_ratio(by_ratio), .o_fixed_root_freq_select(ffs),
        .o_mclk_ratio(mratio), .o_irq(irq));
    initial forever #12.5 i_clk = ~i_clk;
    // Hang guard: the whole run needs about 12800 cycles
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors = errors + 1;
            close_out();
        end
    end
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 cmp({4'h0, rdata}, {4'h0, exp});
    endtask
    task automatic wait_cyc(input int c);
        repeat (c) @(posedge i_clk);
        #1;
    endtask
    // Bit clock rises and cycles between two frame sync rises, sampled settled
    task automatic frame_meas(output int nb, output int per);
        int kk, ss, tt;
        logic qb, qf;
        {kk, nb, ss, tt, qb, qf} = 0;
        while (kk < 2 && ss < 3000) begin
            @(posedge i_clk);
            #1;
            ss++;
            if (bclk && !qb) nb++;
            if (frame_sync && !qf) begin
                kk++;
                if (kk == 1) {nb, tt} = {32'd0, ss};
            end
            {qb, qf} = {bclk, frame_sync};
        end
        per = ss - tt;
    endtask
    task automatic close_out;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(ADDR_MON_STS, 8'hFF);
        rd(ADDR_MASTER_RATE_RATIO_CONFIG, 8'h48);
        rd(ADDR_CLOCK_SOURCE_CONFIG, 8'h10);
        rd(ADDR_PDM_CFG, 8'h40);
        rd(8'h40, 8'h00);
        wr(ADDR_MON_STS, 8'h00);
        rd(ADDR_MON_STS, 8'hFF);
        wr(ADDR_MASTER_RATE_RATIO_CONFIG, 8'h8C);
        rd(ADDR_MASTER_RATE_RATIO_CONFIG, 8'h8C);
        wr(ADDR_CLOCK_SOURCE_CONFIG, 8'hFF);
        rd(ADDR_CLOCK_SOURCE_CONFIG, 8'hF8);
        // Bypassed slave with master clock root: every ratio code
        wr(ADDR_MST_CFG0, 8'h20);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CLOCK_SOURCE_CONFIG, 8'h80 | 8'(c << 3));
            wait_cyc(3);
            cmp(pll_en, 0);
            cmp(root, 1);
            cmp(mratio, tbl[c]);
        end
        wr(ADDR_CLOCK_SOURCE_CONFIG, 8'h40);
        wait_cyc(3);
        cmp(by_ratio, 1);
        cmp(root, 0);
        wr(ADDR_CLOCK_SOURCE_CONFIG, 8'h00);
        // Automatic configuration off: bypass bit has no effect
        wr(ADDR_MST_CFG0, 8'h60);
        wait_cyc(3);
        cmp(pll_en, 1);
        cmp(ffs, 0);
        wr(ADDR_MST_CFG0, 8'h05);
        wait_cyc(3);
        cmp(ffs, 5);
        cmp(by_ratio, 0);
        cmp(pll_en, 1);
        // Slave: valid programmed fields must not make the device drive
        wr(ADDR_MASTER_RATE_RATIO_CONFIG, 8'h44);
        wait_cyc(3);
        cmp({bclk_oe_b, frame_sync_oe_b}, 3);
        run <= 1'b1;
        wait_cyc(2600);
        rd(ADDR_MON_STS, 8'h44);
        // Mask bits enable; all events are masked after reset
        cmp(irq, 0);
        hbits <= 12'd48;
        hframe <= 16'd10000;
        wait_cyc(1700);
        rd(ADDR_MON_STS, 8'hF3);
        hbits <= 12'd40;
        hframe <= 16'd20833;
        wait_cyc(2600);
        rd(ADDR_MON_STS, 8'h4F);
        run <= 1'b0;
        wait_cyc(2200);
        rd(ADDR_MON_STS, 8'hFF);
        // Interrupt: read, enable, clear
        rd(ADDR_IRQ_STS, 8'h03);
        wr(ADDR_IRQ_MASK, 8'h03);
        wait_cyc(3);
        cmp(irq, 1);
        wr(ADDR_IRQ_STS, 8'h03);
        wait_cyc(3);
        cmp(irq, 0);
        wr(ADDR_IRQ_MASK, 8'h00);
        rd(ADDR_IRQ_STS, 8'h00);
        // Master: 48 kHz frames of 64 bit clocks, about 833 cycles each
        wr(ADDR_CLOCK_SOURCE_CONFIG, 8'h38);
        wr(ADDR_MST_CFG0, 8'h80);
        wait_cyc(3);
        cmp({bclk_oe_b, frame_sync_oe_b}, 0);
        cmp(mratio, tbl[7]);
        frame_meas(n, st);
        cmp(12'(n), 64);
        cmp(st inside {[832:834]}, 1);
        // 44.1 kHz family: about 907 cycles a frame
        wr(ADDR_MST_CFG0, 8'h88);
        frame_meas(n, st);
        cmp(12'(n), 64);
        cmp(st inside {[906:908]}, 1);
        // Gate bit holds both clocks low
        wr(ADDR_MST_CFG0, 8'h90);
        wait_cyc(3);
        pb = 0;
        repeat (60) begin
            @(posedge i_clk);
            #1;
            pb |= bclk | frame_sync;
        end
        cmp(pb, 0);
        close_out();
    end
endmodule
`default_nettype wire
